// ### rtl/codec_slot_timing_config.v
// Slot format register and serial-clock slot/frame timing
`timescale 1ns/1ps
`include "slot_timing_consts.vh"
module codec_slot_timing_config (
  input  wire        clk,
  input  wire        reset,
  input  wire [15:0] mcu_addr,
  input  wire        mcu_wr,
  input  wire [7:0]  mcu_wdata,
  input  wire        mcu_rd,
  output reg  [7:0]  mcu_rdata_ff,
  input  wire        codec_port_enable_bit,
  input  wire [4:0]  slot_count,
  input  wire        long_sync_select,
  input  wire [4:0]  secondary_slot,
  input  wire        secondary_enable,
  input  wire        codec_serial_clock,
  output reg         frame_sync_ff,
  output reg  [4:0]  slot_index_ff,
  output reg  [5:0]  bit_index_ff,
  output reg         data_valid_ff,
  output reg         slot_start_ff
);
  // ========================================================================
  // Overview
  // One register holds the three slot format fields; counters read it
  // live, which is safe only because writes are refused while running.
  // Bit 0 of the first slot 0 after enabling lasts from enable to the first rising serial
  // clock edge, so the codec sees a clean frame from the second one on.
  // Serial clock edges are found by clk sampling: the serial clock must
  // stay well under a quarter of clk, or edges are lost.
  // Slot count and secondary slot are read live as well; change them only
  // while the port is off.
  // Reserved codes decode as 8 so a bad write can never stall the counters.
  // Data wider than its slot is cut off at the slot end.
  // ========================================================================
  // Register
  reg  [7:0] slot_format_config_ff;
  reg  [7:0] nxt_rdata;
  // Writes are dropped, not queued, while the port runs
  wire       wr_hit = mcu_wr && (mcu_addr == `SLOT_FORMAT_ADDR) && !codec_port_enable_bit;
  wire       rd_hit = mcu_rd && (mcu_addr == `SLOT_FORMAT_ADDR);
  always @(posedge clk) begin
    if (reset) begin
      slot_format_config_ff <= `SLOT_FORMAT_RESET;
    end else if (wr_hit) begin
      slot_format_config_ff <= mcu_wdata; // see R8
    end
  end

  // Read data is zero outside a read so the bus can be ORed
  always @* begin
    if (rd_hit) begin
      nxt_rdata = slot_format_config_ff;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      mcu_rdata_ff <= 8'h00;
    end else begin
      mcu_rdata_ff <= nxt_rdata;
    end
  end

  // ========================================================================
  // Field decode
  wire [1:0] first_slot_length   = slot_format_config_ff[`FIRST_LEN_HI:`FIRST_LEN_LO];
  wire [2:0] bits_per_slot       = slot_format_config_ff[`BITS_HI:`BITS_LO];
  wire [2:0] general_slot_length = slot_format_config_ff[`GEN_LEN_HI:`GEN_LEN_LO];
  wire [5:0] gen_len;
  wire [5:0] audio_bits;
  slot_len_decode u_gen (
    .code   (general_slot_length), // see R5
    .length (gen_len)
  );
  slot_len_decode u_bits (
    .code   (bits_per_slot), // see R3
    .length (audio_bits)
  );
  reg [5:0] slot0_len;
  always @* begin
    case (first_slot_length)
      2'h1:    slot0_len = `SLOT0_LEN_C1; // see R1
      2'h2:    slot0_len = `SLOT0_LEN_C2; // see R1
      2'h3:    slot0_len = `SLOT0_LEN_C3; // see R1
      default: slot0_len = gen_len; // see R2
    endcase
  end

  // ========================================================================
  // Serial clock sampling: three stages, edge once stages 2 and 3 agree
  reg sclk_s1_ff;
  reg sclk_s2_ff;
  reg sclk_s3_ff;
  reg sclk_lvl_ff;
  always @(posedge clk) begin
    if (reset) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= codec_serial_clock;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
    end
  end

  // Level only moves once two stages agree, so one odd sample is ignored
  always @(posedge clk) begin
    if (reset) begin
      sclk_lvl_ff <= 1'b0;
    end else if (sclk_s2_ff == sclk_s3_ff) begin
      sclk_lvl_ff <= sclk_s3_ff;
    end
  end
  wire sclk_rise = (sclk_s2_ff == sclk_s3_ff) && sclk_s3_ff && !sclk_lvl_ff;

  // ========================================================================
  // Slot and bit counters
  wire       in_slot0  = (slot_index_ff == 5'h00);
  wire       last_slot = (slot_index_ff == slot_count); // see R9
  reg  [5:0] cur_len;
  reg  [5:0] cur_last;
  always @* begin
    if (in_slot0) begin
      cur_len = slot0_len; // see R1
    end else begin
      cur_len = gen_len; // see R5
    end
    cur_last = cur_len - 6'h01;
  end
  wire       last_bit  = (bit_index_ff == cur_last);
  reg  [5:0] nxt_bit;
  reg  [4:0] nxt_slot;
  always @* begin
    nxt_bit  = bit_index_ff;
    nxt_slot = slot_index_ff;
    if (last_bit) begin
      nxt_bit = 6'h00;
      if (last_slot) begin
        nxt_slot = 5'h00; // see R9
      end else begin
        nxt_slot = slot_index_ff + 5'h01; // see R9
      end
    end else begin
      nxt_bit = bit_index_ff + 6'h01;
    end
  end

  // ========================================================================
  // Data window of the slot being entered
  // Judged on the next slot, so a secondary slot is narrow from its first bit
  wire       nxt_is_sec = secondary_enable && (nxt_slot == secondary_slot);
  reg  [5:0] nxt_data_bits;
  always @* begin
    if (nxt_is_sec) begin
      nxt_data_bits = `SEC_SLOT_BITS; // see R4
    end else begin
      nxt_data_bits = audio_bits; // see R3
    end
  end
  // Cycles past the data width are pad
  wire       nxt_valid  = (nxt_bit < nxt_data_bits); // see R7

  // ========================================================================
  // Frame sync next value
  reg        nxt_sync;
  always @* begin
    if (long_sync_select) begin
      nxt_sync = (nxt_slot == 5'h00); // see R10
    end else begin
      nxt_sync = (nxt_slot == 5'h00) && (nxt_bit == 6'h00);
    end
  end

  // ========================================================================
  // Counter registers, held at zero while the port is off
  wire       hold = reset || !codec_port_enable_bit;
  always @(posedge clk) begin
    if (hold) begin
      bit_index_ff  <= 6'h00;
      slot_index_ff <= 5'h00;
    end else if (sclk_rise) begin
      bit_index_ff  <= nxt_bit;
      slot_index_ff <= nxt_slot;
    end
  end

  // ========================================================================
  // Slot start pulse, one clk wide
  always @(posedge clk) begin
    if (hold) begin
      slot_start_ff <= 1'b0;
    end else if (sclk_rise) begin
      slot_start_ff <= (nxt_bit == 6'h00);
    end else begin
      slot_start_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Data valid register
  always @(posedge clk) begin
    if (hold) begin
      data_valid_ff <= 1'b0;
    end else if (sclk_rise) begin
      data_valid_ff <= nxt_valid;
    end
  end

  // ========================================================================
  // Frame sync register
  always @(posedge clk) begin
    if (hold) begin
      frame_sync_ff <= 1'b0;
    end else if (sclk_rise) begin
      frame_sync_ff <= nxt_sync;
    end
  end
endmodule

// ### rtl/slot_timing_consts.vh
// Constants for the codec slot format configuration block
// ==========================================================================
// Behaviour
// R1: First-slot code 01b,10b,11b gives slot 0 of 8,16,32 serial clocks.
// R2: First-slot code 00b makes slot 0 as long as other slots.
// R3: Bits 5:3 pick 8,16,18,20,24,32 data bits per audio slot.
// R4: Secondary communication slots ignore data-bit setting, use fixed format.
// R5: Bits 2:0 pick 8,16,18,20,24,32 serial clocks for slots after 0.
// R6: Software must never program codes 110b or 111b into those fields.
// R7: Data bits should fit the slot; extra cycles carry pad output.
// R8: Register writes take effect only while port enable is clear.
// R9: Slot count field sets 1 to 32 slots; lengths repeat per slot.
// R10: Long sync makes frame sync last as long as slot 0.
// ==========================================================================
`ifndef SLOT_TIMING_CONSTS_VH
`define SLOT_TIMING_CONSTS_VH
`define SLOT_FORMAT_ADDR    16'hffdf
`define SLOT_FORMAT_RESET   8'h00
`define FIRST_LEN_HI        7
`define FIRST_LEN_LO        6
`define BITS_HI             5
`define BITS_LO             3
`define GEN_LEN_HI          2
`define GEN_LEN_LO          0
`define SEC_SLOT_BITS       6'h10
`define LEN_CODE0           6'h08
`define LEN_CODE1           6'h10
`define LEN_CODE2           6'h12
`define LEN_CODE3           6'h14
`define LEN_CODE4           6'h18
`define LEN_CODE5           6'h20
`define LEN_RESERVED        6'h08
`define SLOT0_LEN_C1        6'h08
`define SLOT0_LEN_C2        6'h10
`define SLOT0_LEN_C3        6'h20
`endif

// ### rtl/slot_len_decode.v
// Decoder from a three-bit slot code to a count of serial clocks or bits
`timescale 1ns/1ps
`include "slot_timing_consts.vh"
module slot_len_decode (
  input  wire [2:0] code,
  output reg  [5:0] length
);
  // Reserved codes fall back to 8 so counters never stall
  always @* begin
    case (code)
      3'h0:    length = `LEN_CODE0;
      3'h1:    length = `LEN_CODE1;
      3'h2:    length = `LEN_CODE2;
      3'h3:    length = `LEN_CODE3;
      3'h4:    length = `LEN_CODE4;
      3'h5:    length = `LEN_CODE5;
      default: length = `LEN_RESERVED;
    endcase
  end
endmodule

// ### sim/codec_clock_model.sv
// Codec side model: serial clock source
`timescale 1ns/1ps
module codec_clock_model (
  input  wire run,
  output reg  sclk
);
  // ====
  // Still outside frames, 200 ns period
  initial sclk = 1'b0;
  always #100 sclk = run ? ~sclk : 1'b0;
endmodule

// ### sim/slot_timing_assertions.sv
// Checker for slot timing outputs
`timescale 1ns/1ps
module slot_timing_assertions (
  input wire       clk,
  input wire       reset,
  input wire       codec_port_enable_bit,
  input wire [4:0] slot_count,
  input wire       long_sync_select,
  input wire       frame_sync_ff,
  input wire [4:0] slot_index_ff,
  input wire [5:0] bit_index_ff,
  input wire       slot_start_ff
);
  // ====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_slot0_start;
    slot_start_ff && slot_index_ff == 5'h00;
  endsequence
  a_held_off: assert property (!codec_port_enable_bit && !$past(codec_port_enable_bit)
    |-> slot_index_ff == 5'h00) else $error("counter runs while off");
  a_slot_range: assert property (slot_index_ff <= slot_count)
    else $error("slot index past count");
  a_start_pulse: assert property (slot_start_ff |=> !slot_start_ff)
    else $error("slot start too long");
  a_start_bit: assert property (slot_start_ff |-> bit_index_ff == 6'h00)
    else $error("slot start off bit 0");
  a_sync_slot0: assert property (frame_sync_ff |-> slot_index_ff == 5'h00)
    else $error("sync outside slot 0");
  a_short_sync: assert property (!long_sync_select && frame_sync_ff |-> bit_index_ff == 6'h00)
    else $error("short sync too long");
  a_sync_begin: assert property (s_slot0_start |-> frame_sync_ff)
    else $error("no sync at frame");
endmodule
bind codec_slot_timing_config slot_timing_assertions u_chk (.*);

// ### sim/codec_slot_timing_config_tb.sv
// Testbench for codec slot timing configuration
`timescale 1ns/1ps
module codec_slot_timing_config_tb;
  reg        clk = 0, reset = 1, wr = 0, rd = 0, en = 0, lng = 0, sec = 0, c = 0;
  reg [15:0] addr = 16'h0000;
  reg [7:0]  wdata = 8'h00, mx = 8'h00, dm = 8'h00, fw = 8'h00, ln [2], db [2];
  wire [7:0] rdata;
  wire       sclk, fs, dv, ss;
  wire [4:0] si;
  wire [5:0] bi;
  int        failures = 0, n_tests = 0, i;
  byte       lens [6] = '{8, 16, 18, 20, 24, 32};
  always #12.5 clk = ~clk;
  codec_clock_model u_codec (.run(en), .sclk(sclk));
  codec_slot_timing_config i_dut (.clk(clk), .reset(reset), .mcu_addr(addr), .mcu_wr(wr),
    .mcu_wdata(wdata), .mcu_rd(rd), .mcu_rdata_ff(rdata), .codec_port_enable_bit(en),
    .slot_count(5'h01), .long_sync_select(lng), .secondary_slot(5'h01),
    .secondary_enable(sec), .codec_serial_clock(sclk), .frame_sync_ff(fs),
    .slot_index_ff(si), .bit_index_ff(bi), .data_valid_ff(dv), .slot_start_ff(ss));
  // ====
  // Slot span and data span per slot
  always @(negedge clk) begin
    if (!en) begin
      mx = 8'h00;
      dm = 8'h00;
      fw = 8'h00;
      c = 0;
    end else if (ss) begin
      ln[c] = mx + 8'h01;
      db[c] = dm;
      mx = 8'h00;
      dm = {7'h00, dv};
      c = si[0];
    end else begin
      if (bi > mx) mx = bi;
      if (dv && bi >= dm) dm = bi + 6'h01;
    end
    if (fs && bi >= fw) fw = bi + 6'h01;
  end
  task chk(input string n, input [7:0] s, input [7:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task put(input [7:0] d);
    @(negedge clk);
    addr = 16'hffdf;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task get(input [15:0] a, input [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk("reg", rdata, e);
  endtask
  task run(input [7:0] v);
    put(v);
    en = 1;
    repeat (1600) @(negedge clk);
    en = 0;
  endtask
  task wrap_up;
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ====
  // Tests
  initial begin
    repeat (2) @(negedge clk);
    reset = 0;
    get(16'hffdf, 8'h00);
    get(16'hffde, 8'h00);
    for (i = 0; i < 6; i++) begin
      run({2'b00, i[2:0], i[2:0]});
      chk("slot0", ln[0], lens[i]);
      chk("slot1", ln[1], lens[i]);
      chk("bits", db[1], lens[i]);
      chk("sync", fw, 8'h01);
    end
    for (i = 1; i < 4; i++) begin
      run({i[1:0], 6'h05});
      chk("first", ln[0], 8'h04 << i);
      chk("pad", db[1], 8'h08);
    end
    sec = 1;
    lng = 1;
    run(8'h2d);
    chk("sec", db[1], 8'h10);
    chk("lsync", fw, 8'h20);
    en = 1;
    put(8'h00);
    en = 0;
    get(16'hffdf, 8'h2d);
    wrap_up;
  end
  // Bound well past ten runs of 1600 cycles
  initial begin
    #2000000;
    failures++;
    wrap_up;
  end
endmodule
